// ==== verilog/flash_read_pkg.sv ====
// constants shared by the mapped flash read path
// assumes a 32-bit avalon-mm slave and a one/four lane serial flash
package flash_read_pkg;
   // register word indexes, byte address is index times four
   localparam logic [2:0] REG_RATE = 3'h0;
   localparam logic [2:0] REG_CMD = 3'h1;
   localparam logic [2:0] REG_ENA = 3'h2;
   localparam logic [2:0] REG_OPT = 3'h3;
   localparam logic [2:0] REG_DDR = 3'h4;
   localparam logic [2:0] REG_STAT = 3'h5;
   // rate register fields
   localparam int RATE_VAL_LO = 0;
   localparam int RATE_DIV_LO = 8;
   // enable register fields
   localparam int ENA_ALANE4 = 1;
   localparam int ENA_OLANE4 = 3;
   localparam int ENA_ADE_LO = 4;
   localparam int ENA_OPDE_LO = 8;
   localparam int ENA_DLANE4 = 13;
   localparam int ENA_DME = 14;
   localparam int ENA_DMY_LO = 16;
   // double rate register fields
   localparam int DDR_ADDR = 0;
   localparam int DDR_OPT = 1;
   localparam int DDR_DATA = 2;
   // address enable codes
   localparam logic [3:0] ADE_24 = 4'h7;
   localparam logic [3:0] ADE_32 = 4'hF;
   // writable masks, other bits read zero
   localparam logic [31:0] MASK_RATE = 32'h0000_03FF;
   localparam logic [31:0] MASK_CMD = 32'h0000_00FF;
   localparam logic [31:0] MASK_ENA = 32'h0007_7FFA;
   localparam logic [31:0] MASK_OPT = 32'hFFFF_FFFF;
   localparam logic [31:0] MASK_DDR = 32'h0000_0007;
   // reset values
   localparam logic [31:0] RST_RATE = 32'h0000_0001;
   localparam logic [31:0] RST_CMD = 32'h0000_0003;
   localparam logic [31:0] RST_ENA = 32'h0000_0070;
   localparam logic [31:0] RST_OPT = 32'h0000_0000;
   localparam logic [31:0] RST_DDR = 32'h0000_0000;
   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_CMD = 3'b001,
      PH_ADDR = 3'b011,
      PH_OPT = 3'b010,
      PH_DUMMY = 3'b110,
      PH_DATA = 3'b111,
      PH_DONE = 3'b101
   } phase_t;
endpackage : flash_read_pkg

// ==== verilog/spi_flash_mapped_read.sv ====
// mapped read path: avalon-mm reads of the flash window become serial flash reads
// assumes one bus master, a flash that drives read data just after each serial clock edge
`timescale 1ns/1ps

module spi_flash_mapped_read #(
   parameter int ADDR_W = 26
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic flash_serial_clock_out,
   output logic flash_cs_n,
   output logic [3:0] io_out,
   output logic [3:0] io_oe_n,
   input wire logic [3:0] io_in
);

   if (ADDR_W < 6 || ADDR_W > 33) begin : g_chk
      $error("ADDR_W must lie in 6..33");
   end

   function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be, input logic [31:0] mask);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i+:8] = new_v[8*i+:8];
         end
      end
      return r & mask;
   endfunction : be_merge

   function automatic flash_read_pkg::phase_t next_phase(input flash_read_pkg::phase_t s,
                                                         input logic a_en, input logic o_en,
                                                         input logic d_en);
      flash_read_pkg::phase_t after_opt;
      after_opt = d_en ? flash_read_pkg::PH_DUMMY : flash_read_pkg::PH_DATA;
      unique case (s)
         flash_read_pkg::PH_IDLE: next_phase = flash_read_pkg::PH_CMD;
         flash_read_pkg::PH_CMD: next_phase = a_en ? flash_read_pkg::PH_ADDR :
                                              o_en ? flash_read_pkg::PH_OPT : after_opt;
         flash_read_pkg::PH_ADDR: next_phase = o_en ? flash_read_pkg::PH_OPT : after_opt;
         flash_read_pkg::PH_OPT: next_phase = after_opt;
         flash_read_pkg::PH_DUMMY: next_phase = flash_read_pkg::PH_DATA;
         flash_read_pkg::PH_DATA: next_phase = flash_read_pkg::PH_DONE;
         flash_read_pkg::PH_DONE: next_phase = flash_read_pkg::PH_IDLE;
         default: next_phase = flash_read_pkg::PH_IDLE;
      endcase
   endfunction : next_phase

   logic [31:0] cfg_rate_ff;
   logic [31:0] cfg_cmd_ff;
   logic [31:0] cfg_ena_ff;
   logic [31:0] cfg_opt_ff;
   logic [31:0] cfg_ddr_ff;
   logic [31:0] rdata_ff;
   logic ack_ff;
   logic [15:0] xfer_cnt_ff;
   flash_read_pkg::phase_t st_ff;
   flash_read_pkg::phase_t np;
   logic [11:0] div_cnt_ff;
   logic sclk_ff;
   logic cs_n_ff;
   logic rise_seen_ff;
   logic lane4_ff;
   logic ddr_on_ff;
   logic tx_ff;
   logic [5:0] beats_ff;
   logic [31:0] sr_ff;
   logic [31:0] rx_ff;
   logic [3:0] din_s1_ff;
   logic [3:0] din_s2_ff;

   // bus decode
   wire reg_sel = avs_address[ADDR_W-1];
   wire [2:0] reg_idx = avs_address[4:2];
   wire req = avs_read | avs_write;
   wire reg_wr = avs_write & reg_sel & ack_ff;
   wire is_idle = st_ff == flash_read_pkg::PH_IDLE;
   wire is_done = st_ff == flash_read_pkg::PH_DONE;
   // the ack cycle itself blocks a restart, so one read never runs twice
   wire start = avs_read & ~reg_sel & is_idle & ~ack_ff;
   wire nxt_ack = ~ack_ff & req & (reg_sel | avs_write | is_done);
   wire [31:0] stat_word = {16'h0000, xfer_cnt_ff};
   wire [31:0] reg_rd = reg_idx == flash_read_pkg::REG_RATE ? cfg_rate_ff :
                        reg_idx == flash_read_pkg::REG_CMD ? cfg_cmd_ff :
                        reg_idx == flash_read_pkg::REG_ENA ? cfg_ena_ff :
                        reg_idx == flash_read_pkg::REG_OPT ? cfg_opt_ff :
                        reg_idx == flash_read_pkg::REG_DDR ? cfg_ddr_ff :
                        reg_idx == flash_read_pkg::REG_STAT ? stat_word : 32'h0000_0000;
   // first flash byte lands in the lowest lane
   wire [31:0] rx_word = {rx_ff[7:0], rx_ff[15:8], rx_ff[23:16], rx_ff[31:24]};
   wire [31:0] nxt_rdata = is_done ? rx_word :
                           (avs_read & reg_sel & ~ack_ff) ? reg_rd : rdata_ff;

   assign avs_waitrequest = req & ~ack_ff;
   assign avs_readdata = rdata_ff;

   // configuration decode
   wire [3:0] ade = cfg_ena_ff[flash_read_pkg::ENA_ADE_LO+:4];
   wire [3:0] opde = cfg_ena_ff[flash_read_pkg::ENA_OPDE_LO+:4];
   wire [2:0] dmy = cfg_ena_ff[flash_read_pkg::ENA_DMY_LO+:3];
   wire a32 = ade == flash_read_pkg::ADE_32;
   wire a_en = a32 | (ade == flash_read_pkg::ADE_24);
   // option bytes count down from the top byte, other codes send none
   wire [2:0] o_n = opde == 4'h8 ? 3'h1 : opde == 4'hC ? 3'h2 :
                    opde == 4'hE ? 3'h3 : opde == 4'hF ? 3'h4 : 3'h0;
   wire o_en = o_n != 3'h0;
   wire d_en = cfg_ena_ff[flash_read_pkg::ENA_DME] & (dmy != 3'h0);
   wire [31:0] flash_addr = 32'({avs_address[ADDR_W-2:2], 2'b00});

   assign np = next_phase(st_ff, a_en, o_en, d_en);

   wire ld_cmd = np == flash_read_pkg::PH_CMD;
   wire ld_addr = np == flash_read_pkg::PH_ADDR;
   wire ld_opt = np == flash_read_pkg::PH_OPT;
   wire ld_dmy = np == flash_read_pkg::PH_DUMMY;
   wire ld_data = np == flash_read_pkg::PH_DATA;
   wire [31:0] ld_sr = ld_cmd ? {cfg_cmd_ff[7:0], 24'h00_0000} :
                       ld_addr ? (a32 ? flash_addr : {flash_addr[23:0], 8'h00}) :
                       ld_opt ? cfg_opt_ff : 32'h0000_0000;
   wire [5:0] ld_bits = ld_cmd ? 6'h08 :
                        ld_addr ? (a32 ? 6'h20 : 6'h18) :
                        ld_opt ? {o_n, 3'b000} :
                        ld_dmy ? {3'b000, dmy} :
                        ld_data ? 6'h20 : 6'h00;
   wire ld_lane4 = ld_addr ? cfg_ena_ff[flash_read_pkg::ENA_ALANE4] :
                   ld_opt ? cfg_ena_ff[flash_read_pkg::ENA_OLANE4] :
                   ld_data & cfg_ena_ff[flash_read_pkg::ENA_DLANE4];
   wire [5:0] ld_beats = ld_lane4 ? {2'b00, ld_bits[5:2]} : ld_bits;
   wire ld_ddr = ld_addr ? cfg_ddr_ff[flash_read_pkg::DDR_ADDR] :
                 ld_opt ? cfg_ddr_ff[flash_read_pkg::DDR_OPT] :
                 ld_data & cfg_ddr_ff[flash_read_pkg::DDR_DATA];
   wire ld_tx = ld_cmd | ld_addr | ld_opt;

   // serial clock timing
   wire active = ~is_idle & ~is_done;
   wire [11:0] half = (12'(cfg_rate_ff[7:0]) + 12'h001) << cfg_rate_ff[9:8];
   wire tick = active & (div_cnt_ff == half - 12'h001);
   wire rising = ~sclk_ff;
   // single rate beats end on a falling edge that follows a rising one
   wire adv = tick & (ddr_on_ff | (sclk_ff & rise_seen_ff));
   wire last = beats_ff == 6'h01;
   wire load_now = start | (adv & last);
   wire smp = tick & (st_ff == flash_read_pkg::PH_DATA) & (ddr_on_ff | rising);
   wire [31:0] sr_shift = lane4_ff ? {sr_ff[27:0], 4'h0} : {sr_ff[30:0], 1'b0};
   wire [31:0] rx_shift = lane4_ff ? {rx_ff[27:0], din_s2_ff} :
                          {rx_ff[30:0], din_s2_ff[1]};

   assign flash_serial_clock_out = sclk_ff;
   assign flash_cs_n = cs_n_ff;
   assign io_out = ~tx_ff ? 4'h0 : lane4_ff ? sr_ff[31:28] : {3'b000, sr_ff[31]};
   assign io_oe_n = ~tx_ff ? 4'hF : lane4_ff ? 4'h0 : 4'hE;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else if (ce) begin
         ack_ff <= nxt_ack;
         rdata_ff <= nxt_rdata;
      end
   end

   // writes land on the edge where waitrequest is seen low
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cfg_rate_ff <= flash_read_pkg::RST_RATE;
         cfg_cmd_ff <= flash_read_pkg::RST_CMD;
         cfg_ena_ff <= flash_read_pkg::RST_ENA;
         cfg_opt_ff <= flash_read_pkg::RST_OPT;
         cfg_ddr_ff <= flash_read_pkg::RST_DDR;
      end else if (ce && reg_wr) begin
         if (reg_idx == flash_read_pkg::REG_RATE) begin
            cfg_rate_ff <= be_merge(cfg_rate_ff, avs_writedata, avs_byteenable,
                                    flash_read_pkg::MASK_RATE);
         end
         if (reg_idx == flash_read_pkg::REG_CMD) begin
            cfg_cmd_ff <= be_merge(cfg_cmd_ff, avs_writedata, avs_byteenable,
                                   flash_read_pkg::MASK_CMD);
         end
         if (reg_idx == flash_read_pkg::REG_ENA) begin
            cfg_ena_ff <= be_merge(cfg_ena_ff, avs_writedata, avs_byteenable,
                                   flash_read_pkg::MASK_ENA);
         end
         if (reg_idx == flash_read_pkg::REG_OPT) begin
            cfg_opt_ff <= be_merge(cfg_opt_ff, avs_writedata, avs_byteenable,
                                   flash_read_pkg::MASK_OPT);
         end
         if (reg_idx == flash_read_pkg::REG_DDR) begin
            cfg_ddr_ff <= be_merge(cfg_ddr_ff, avs_writedata, avs_byteenable,
                                   flash_read_pkg::MASK_DDR);
         end
      end
   end

   // flash lanes are asynchronous to sys_clk
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         din_s1_ff <= 4'h0;
         din_s2_ff <= 4'h0;
      end else if (ce) begin
         din_s1_ff <= io_in;
         din_s2_ff <= din_s1_ff;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_ff <= flash_read_pkg::PH_IDLE;
         div_cnt_ff <= 12'h000;
         sclk_ff <= 1'b0;
         cs_n_ff <= 1'b1;
         rise_seen_ff <= 1'b0;
         xfer_cnt_ff <= 16'h0000;
      end else if (ce) begin
         if (load_now) begin
            st_ff <= np;
         end else if (is_done) begin
            st_ff <= flash_read_pkg::PH_IDLE;
         end
         if (start) begin
            cs_n_ff <= 1'b0;
         end else if (load_now && np == flash_read_pkg::PH_DONE) begin
            cs_n_ff <= 1'b1;
         end
         if (is_done) begin
            xfer_cnt_ff <= xfer_cnt_ff + 16'h0001;
         end
         div_cnt_ff <= (start | tick | ~active) ? 12'h000 : div_cnt_ff + 12'h001;
         if (~active || (load_now && np == flash_read_pkg::PH_DONE)) begin
            sclk_ff <= 1'b0;
         end else if (tick) begin
            sclk_ff <= ~sclk_ff;
         end
         if (load_now || adv) begin
            rise_seen_ff <= 1'b0;
         end else if (tick && rising) begin
            rise_seen_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sr_ff <= 32'h0000_0000;
         rx_ff <= 32'h0000_0000;
         beats_ff <= 6'h00;
         lane4_ff <= 1'b0;
         ddr_on_ff <= 1'b0;
         tx_ff <= 1'b0;
      end else if (ce) begin
         if (load_now) begin
            sr_ff <= ld_sr;
            beats_ff <= ld_beats;
            lane4_ff <= ld_lane4;
            ddr_on_ff <= ld_ddr;
            tx_ff <= ld_tx;
         end else if (adv) begin
            sr_ff <= sr_shift;
            beats_ff <= beats_ff - 6'h01;
         end
         if (smp) begin
            rx_ff <= rx_shift;
         end
      end
   end

endmodule : spi_flash_mapped_read

// ==== test/flash_partner.sv ====
// serial flash stand-in: records the driven lanes on each rising serial clock edge, returns a word on the read lanes
// assumes the bench supplies the word, lane width, data rate and lead in clock periods
`timescale 1ns/1ps
module flash_partner (
   input wire logic sys_clk,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe_n,
   input wire logic [31:0] word,
   input wire logic quad,
   input wire logic ddr,
   input wire logic [7:0] lead,
   output logic [3:0] io_in,
   output logic [127:0] rx,
   output logic [7:0] rx_n
);
   logic sc_d = 1'b0;
   logic cs_d = 1'b1;
   int e = 0;
   int k;
   initial io_in = 4'h5;
   initial rx = '0;
   initial rx_n = '0;
   always @(posedge sys_clk) begin
      sc_d <= sclk;
      cs_d <= cs_n;
      if (cs_n) e = 0;
      else if (sclk != sc_d) e = e + 1;
      if (!cs_n && cs_d) begin
         rx <= '0;
         rx_n <= '0;
      end else if (sclk && !sc_d && io_oe_n != 4'hF) begin
         rx <= (io_oe_n == 4'hE) ? {rx[126:0], io_out[0]} : {rx[123:0], io_out};
         rx_n <= rx_n + ((io_oe_n == 4'hE) ? 8'h01 : 8'h04);
      end
      k = ddr ? e - 2 * lead : e / 2 - lead;
      // released or idle lanes never keep a stale value
      if (cs_n || io_oe_n != 4'hF || k < 0 || k >= (quad ? 8 : 32)) io_in <= ~io_in;
      else if (quad) io_in <= word[8 * (k / 2) + ((k % 2) ? 0 : 4) +: 4];
      else io_in <= {~io_in[3:2], word[8 * (k / 8) + 7 - k % 8], ~io_in[0]};
   end
endmodule : flash_partner

// ==== test/spi_flash_mapped_read_checker.sv ====
// port checker for the mapped flash read path
// assumes ce held high; tracks the rate register from bus writes
`timescale 1ns/1ps
module spi_flash_mapped_read_checker #(
   parameter int ADDR_W = 26
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic flash_serial_clock_out,
   input wire logic flash_cs_n,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe_n,
   input wire logic [3:0] io_in
);
   logic [9:0] rate_ff;
   logic [15:0] cnt_ff;
   logic sclk_ff;
   wire rate_wr = avs_write && !avs_waitrequest && avs_address[ADDR_W-1]
      && avs_address[4:2] == 3'h0;
   wire flash_rd = avs_read && !avs_address[ADDR_W-1];
   wire lanes_off = io_oe_n == 4'hF;
   wire [15:0] half = ({8'h00, rate_ff[7:0]} + 16'h0001) << rate_ff[9:8];
   wire req = avs_read || avs_write;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rate_ff <= 10'h001;
         cnt_ff <= 16'h0000;
         sclk_ff <= 1'b0;
      end else begin
         if (rate_wr && avs_byteenable[0]) rate_ff[7:0] <= avs_writedata[7:0];
         if (rate_wr && avs_byteenable[1]) rate_ff[9:8] <= avs_writedata[9:8];
         sclk_ff <= flash_serial_clock_out;
         cnt_ff <= (flash_serial_clock_out != sclk_ff) ? 16'h0001 : cnt_ff + 16'h0001;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   idle_clock_low_a: assert property (flash_cs_n |-> !flash_serial_clock_out)
      else $error("serial clock high while deselected");
   high_phase_len_a: assert property ($fell(flash_serial_clock_out) |-> cnt_ff == half)
      else $error("serial clock high phase wrong length");
   lane_enable_a: assert property (io_oe_n inside {4'hE, 4'h0, 4'hF})
      else $error("lane enables not one or four lanes");
   opcode_one_lane_a: assert property ($fell(flash_cs_n) |-> (io_oe_n == 4'hE) [*8])
      else $error("opcode not on one lane");
   release_held_a: assert property (!flash_cs_n && lanes_off |=> flash_cs_n || lanes_off)
      else $error("lanes driven again after release");
   deselect_off_a: assert property (flash_cs_n |-> io_oe_n == 4'hF)
      else $error("lanes driven while deselected");
   flash_ack_idle_a: assert property (flash_rd && !avs_waitrequest |-> flash_cs_n)
      else $error("flash read answered mid transfer");
   read_starts_a: assert property ($rose(avs_read) && flash_rd |-> ##[1:2] !flash_cs_n)
      else $error("flash read did not select");
   single_ack_a: assert property (req && !avs_waitrequest |=> !req || avs_waitrequest)
      else $error("answer longer than one cycle");
   cover property (io_oe_n == 4'h0);
   cover property ($rose(flash_cs_n));
   cover property (rate_wr);
endmodule : spi_flash_mapped_read_checker

// ==== test/spi_flash_mapped_read_bench.sv ====
// bench for the mapped flash read path: registers and flash reads over many settings
// assumes the flash stand-in and the port checker are compiled alongside
`timescale 1ns/1ps
module spi_flash_mapped_read_bench;
   localparam int AW = 26;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [AW-1:0] adr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = '0;
   logic [3:0] be = 4'hF;
   logic [31:0] rdata;
   logic wait_rq;
   logic sclk;
   logic cs_n;
   logic [3:0] io_out;
   logic [3:0] io_oe_n;
   logic [3:0] io_in;
   logic [31:0] word = '0;
   logic quad = 1'b0;
   logic ddr = 1'b0;
   logic [7:0] lead = '0;
   logic [127:0] rx;
   logic [7:0] rx_n;
   int err_count = 0;
   int n_tests = 0;
   logic [31:0] shadow [8];
   localparam logic [31:0] MSK [8] = '{flash_read_pkg::MASK_RATE, flash_read_pkg::MASK_CMD,
      flash_read_pkg::MASK_ENA, flash_read_pkg::MASK_OPT, flash_read_pkg::MASK_DDR, 32'h0, 32'h0,
      32'h0};
   always #12.5 sys_clk = ~sys_clk;
   spi_flash_mapped_read #(.ADDR_W(AW)) u_spi_flash_mapped_read (.sys_clk(sys_clk), .rst(rst),
      .ce(1'b1), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_rq),
      .flash_serial_clock_out(sclk), .flash_cs_n(cs_n), .io_out(io_out), .io_oe_n(io_oe_n),
      .io_in(io_in));
   flash_partner u_flash_partner (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .io_out(io_out),
      .io_oe_n(io_oe_n), .word(word), .quad(quad), .ddr(ddr), .lead(lead), .io_in(io_in),
      .rx(rx), .rx_n(rx_n));
   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %0t: word %h, wanted %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_rx(input logic [127:0] exp, input int n);
      n_tests++;
      if (rx_n !== 8'(n) || (rx & ((128'h1 << n) - 1)) !== exp) begin
         err_count++;
         $display("unexpected %0t: flash got %0d bits %h", $time, rx_n, rx);
      end
   endtask : chk_rx
   task automatic bus(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
         input logic [3:0] b, output logic [31:0] q);
      int j;
      @(posedge sys_clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      be <= b;
      for (j = 0; j < 30000; j++) begin
         @(posedge sys_clk);
         if (wait_rq === 1'b0) break;
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (j == 30000) begin
         err_count++;
         $display("unexpected %0t: no answer", $time);
         results;
      end
   endtask : bus
   function automatic logic [AW-1:0] ra(input int i);
      return (AW'(1) << (AW - 1)) | AW'(i << 2);
   endfunction : ra
   task automatic rw(input int i, input logic [31:0] d, input logic [3:0] b);
      logic [31:0] q;
      logic [31:0] m;
      m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & MSK[i];
      shadow[i] = (shadow[i] & ~m) | (d & m);
      bus(1'b1, ra(i), d, b, q);
   endtask : rw
   task automatic rchk(input int i);
      logic [31:0] q;
      bus(1'b0, ra(i), 32'h0, 4'hF, q);
      chk(q, shadow[i]);
   endtask : rchk
   task automatic run_cfg(input logic [7:0] rt, input logic [1:0] dv, input logic al4, ol4,
         input logic [3:0] ade, opde, input logic dl4, dme, input logic [2:0] dmy, dr);
      logic [31:0] q;
      logic [31:0] w;
      logic [AW-1:0] fa;
      logic [127:0] ex;
      int ab;
      int ob;
      rw(0, {22'h0, dv, rt}, 4'hF);
      rw(1, $urandom, 4'hF);
      rw(2, {13'h0, dmy, 1'b0, dme, dl4, 1'b0, opde, ade, ol4, 1'b0, al4, 1'b0}, 4'hF);
      rw(3, $urandom, 4'hF);
      rw(4, {29'h0, dr}, 4'hF);
      ab = (ade == 4'hF) ? 32 : (ade == 4'h7) ? 24 : 0;
      ob = (opde == 4'hF) ? 32 : (opde == 4'hE) ? 24 : (opde == 4'hC) ? 16 :
         (opde == 4'h8) ? 8 : 0;
      lead <= 8'(8 + ab / (al4 ? 4 : 1) / (dr[0] ? 2 : 1) + ob / (ol4 ? 4 : 1) / (dr[1] ? 2 : 1)
         + (dme ? dmy : 0));
      quad <= dl4;
      ddr <= dr[2];
      // two reads back to back with a fresh word each
      repeat (2) begin
         fa = AW'($urandom) & ~(AW'(1) << (AW - 1)) & ~AW'(3);
         w = $urandom;
         word <= w;
         bus(1'b0, fa, 32'h0, 4'hF, q);
         shadow[5]++;
         chk(q, w);
         ex = 128'(shadow[1][7:0]);
         if (ab > 0) ex = (ex << ab) | 128'((ab == 24) ? 32'(fa[23:0]) : 32'(fa));
         ex = (ex << ob) | 128'(shadow[3] >> (32 - ob));
         if (dr[1:0] == 2'b00) chk_rx(ex, 8 + ab + ob);
      end
   endtask : run_cfg
   initial begin
      logic [31:0] q;
      void'($urandom(32'hebec03c2));
      shadow = '{flash_read_pkg::RST_RATE, flash_read_pkg::RST_CMD, flash_read_pkg::RST_ENA,
         flash_read_pkg::RST_OPT, flash_read_pkg::RST_DDR, 32'h0, 32'h0, 32'h0};
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) rchk(i);
      for (int i = 0; i < 8; i++) rw(i, $urandom, 4'($urandom));
      for (int i = 0; i < 8; i++) rchk(i);
      run_cfg(8'h03, 2'h0, 0, 0, 4'h7, 4'h0, 0, 0, 3'h0, 3'h0);
      run_cfg(8'h01, 2'h1, 1, 0, 4'hF, 4'hC, 1, 1, 3'h4, 3'h0);
      run_cfg(8'h00, 2'h2, 0, 1, 4'h7, 4'hF, 0, 1, 3'h0, 3'h0);
      run_cfg(8'h05, 2'h0, 0, 0, 4'h7, 4'hE, 1, 1, 3'h7, 3'h4);
      run_cfg(8'h01, 2'h1, 1, 1, 4'hF, 4'h8, 0, 1, 3'h2, 3'h3);
      run_cfg(8'h03, 2'h1, 0, 0, 4'h0, 4'h0, 1, 0, 3'h5, 3'h4);
      // mid-run reset must bring every register and the read count back
      rst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      shadow = '{flash_read_pkg::RST_RATE, flash_read_pkg::RST_CMD, flash_read_pkg::RST_ENA,
         flash_read_pkg::RST_OPT, flash_read_pkg::RST_DDR, 32'h0, 32'h0, 32'h0};
      bus(1'b1, AW'(64), 32'hFFFF_FFFF, 4'hF, q);
      for (int i = 0; i < 8; i++) rchk(i);
      results;
   end
endmodule : spi_flash_mapped_read_bench
bind spi_flash_mapped_read spi_flash_mapped_read_checker #(.ADDR_W(ADDR_W)) u_chk (
   .sys_clk(sys_clk), .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .flash_serial_clock_out(flash_serial_clock_out), .flash_cs_n(flash_cs_n), .io_out(io_out),
   .io_oe_n(io_oe_n), .io_in(io_in));
